/* File: mrjd_cfg.svh */
/*
  Constants of the mono right-justified serial input front end.
  Assumes a 200 MHz system clock sampling the link pins.
*/
`ifndef MRJD_CFG_SVH
`define MRJD_CFG_SVH
`define MRJD_WORD_W        16
`define MRJD_MID_CODE      16'h0000
`define MRJD_FIFO_DEPTH    8
`define MRJD_CLK_PERIOD_PS 5000
`define MRJD_POR_TIME_NS   30000
`define MRJD_POR_CYCLES    ((`MRJD_POR_TIME_NS * 1000) / `MRJD_CLK_PERIOD_PS)
`define MRJD_LOAD_EDGE     2
`endif

/* File: mrjd_fifo.sv */
/*
  Holds no logic: the hand-off FIFO module is declared in mrjd_input.sv,
  next to its only user.
  Assumes mrjd_input.sv is part of the same build.
*/

/* File: mrjd_host.sv */
/*
  Host model driving the three-wire link.
  Assumes clk_in at 200 MHz; bit clock of 80 ns, evenly spaced across
  back-to-back frames.
*/
module mrjd_host
  import mrjd_pkg::*;
(
  input  wire logic clk_in,
  output mrjd_link_s link_out
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t_rise2;
  initial link_out = 3'b001;
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  task automatic tick();
    link_out.bit_clk = 1'b1;
    half();
    link_out.bit_clk = 1'b0;
  endtask
  // Twenty bits so the four leading bits must be dropped
  task automatic send(input logic [19:0] w);
    for (int i = 19; i >= 0; i--) begin
      link_out.serial_data = w[i];
      half();
      tick();
    end
    link_out.word_sync = 1'b0;
    // Data line is released: show the inverse so a stale bit cannot pass
    link_out.serial_data = ~link_out.serial_data;
    half();
    tick();
    half();
    t_rise2 = $realtime;
    tick();
    // No idle half here, so the next frame's first rise keeps the period
    link_out.word_sync = 1'b1;
  endtask
endmodule

/* File: mrjd_input.sv */
/*
  Serial input front end: shift register, holding register, converter latch
  load and filter hand-off through the FIFO module at the end of this file.
  Assumes the link pins are asynchronous to clk_in; the filter sits outside
  and drains filt_ready_in.
*/
`include "mrjd_cfg.svh"
module mrjd_input
  import mrjd_pkg::*;
#(
  parameter int POR_CYCLES = `MRJD_POR_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire mrjd_link_s link_in,
  input  wire mrjd_ctrl_s ctrl_in,
  output mrjd_word_t      dac_latch_out,
  output logic            dac_load_out,
  output mrjd_word_t      filt_data_out,
  output logic            filt_valid_out,
  input  wire logic       filt_ready_in,
  output logic            filt_run_out,
  output logic            overrun_out
);
  mrjd_link_s link_s1_q;
  mrjd_link_s link_s2_q;
  mrjd_link_s link_s3_q;
  mrjd_ctrl_s ctrl_s1_q;
  mrjd_ctrl_s ctrl_s2_q;
  mrjd_word_t shift_q;
  mrjd_word_t hold_q;
  mrjd_word_t latch_q;
  mrjd_xfer_e xfer_q;
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_q;
  logic       por_done_q;
  logic       load_q;
  logic       fvalid_q;
  logic       frdy;
  logic       fifo_valid;
  mrjd_word_t fifo_data;
  logic       ovr_q;
  logic       run_q;
  mrjd_word_t fdata_q;
  logic       fval_q;

  // Second stage only is read; third stage exists for edge detection
  always_ff @(posedge clk_in) begin
    link_s1_q <= link_in;
    link_s2_q <= link_s1_q;
    link_s3_q <= link_s2_q;
    ctrl_s1_q <= ctrl_in;
    ctrl_s2_q <= ctrl_s1_q;
  end

  // Edges compare the second synchroniser stage with the stage after it
  function automatic logic edge_up(input logic now_v, input logic was_v);
    return now_v && !was_v;
  endfunction

  function automatic logic edge_down(input logic now_v, input logic was_v);
    return !now_v && was_v;
  endfunction

  wire sck_rise  = edge_up(link_s2_q.bit_clk, link_s3_q.bit_clk);
  wire sync_fall = edge_down(link_s2_q.word_sync, link_s3_q.word_sync);
  wire bypass    = !ctrl_s2_q.filter_bypass_n || !ctrl_s2_q.filter_clear_n;

  // Shifting never stops, so only the newest 16 bits survive
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_q <= `MRJD_MID_CODE;
    end else if (sck_rise) begin
      shift_q <= {shift_q[`MRJD_WORD_W-2:0], link_s2_q.serial_data};
    end
  end

  // Word-sync is sampled with the same delay as the bit clock, so a fall
  // and a rise in one cycle see the shift value before that rise.
  always_ff @(posedge clk_in) begin
    if (rst_in || !por_done_q) begin
      hold_q <= `MRJD_MID_CODE;
    end else if (sync_fall) begin
      hold_q <= shift_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_cnt_q  <= por_cnt_q + 1'b1;
      por_done_q <= por_cnt_q == ($clog2(POR_CYCLES+1))'(POR_CYCLES - 1);
    end
  end

  // Counts bit-clock rises after the word-sync fall
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xfer_q <= MRJD_IDLE;
    end else if (sync_fall) begin
      xfer_q <= MRJD_WAIT1;
    end else if (sck_rise) begin
      case (xfer_q)
        MRJD_WAIT1: xfer_q <= MRJD_WAIT2;
        MRJD_WAIT2: xfer_q <= MRJD_IDLE;
        default:    xfer_q <= MRJD_IDLE;
      endcase
    end
  end

  wire xfer_now = sck_rise && xfer_q == MRJD_WAIT2;

  always_ff @(posedge clk_in) begin
    if (rst_in || !por_done_q) begin
      latch_q <= `MRJD_MID_CODE;
      load_q  <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (xfer_now && !ctrl_s2_q.output_clear_n) begin
        latch_q <= `MRJD_MID_CODE;
        load_q  <= 1'b1;
      end else if (xfer_now && bypass) begin
        latch_q <= hold_q;
        load_q  <= 1'b1;
      end
    end
  end

  // Filter path stays fed while filter_bypass_n bypasses it, so it computes behind the latch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fvalid_q <= 1'b0;
      ovr_q    <= 1'b0;
    end else begin
      fvalid_q <= xfer_now && ctrl_s2_q.filter_clear_n;
      ovr_q    <= fvalid_q && !frdy;
    end
  end

  mrjd_word_t fin_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fin_q <= `MRJD_MID_CODE;
    end else if (xfer_now) begin
      fin_q <= hold_q;
    end
  end

  mrjd_fifo #(.WIDTH(`MRJD_WORD_W), .DEPTH(`MRJD_FIFO_DEPTH)) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in || !ctrl_s2_q.filter_clear_n),
    .wr_data_in   (fin_q),
    .wr_valid_in  (fvalid_q),
    .wr_ready_out (frdy),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (!fval_q || filt_ready_in)
  );

  // Output register slice keeps every output straight from a flip-flop
  always_ff @(posedge clk_in) begin
    if (rst_in || !ctrl_s2_q.filter_clear_n) begin
      fval_q  <= 1'b0;
      fdata_q <= `MRJD_MID_CODE;
    end else if (!fval_q || filt_ready_in) begin
      fval_q  <= fifo_valid;
      fdata_q <= fifo_data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= ctrl_s2_q.filter_clear_n && por_done_q;
    end
  end

  assign dac_latch_out  = latch_q;
  assign dac_load_out   = load_q;
  assign filt_data_out  = fdata_q;
  assign filt_valid_out = fval_q;
  assign filt_run_out   = run_q;
  assign overrun_out    = ovr_q;

  a_load_timing: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer_now && por_done_q && (bypass || !ctrl_s2_q.output_clear_n)
    |=> dac_load_out)
    else $error("load missing after second bit-clock rise");
  a_clear_mid: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer_now && por_done_q && !ctrl_s2_q.output_clear_n |=> dac_latch_out == 16'h0000)
    else $error("clear did not give mid-scale");
  a_bypass_val: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer_now && por_done_q && ctrl_s2_q.output_clear_n && bypass
    |=> dac_latch_out == $past(hold_q))
    else $error("bypass value wrong");
  a_hold_copy: assert property (@(posedge clk_in) disable iff (rst_in)
    sync_fall && por_done_q |=> hold_q == $past(shift_q))
    else $error("holding register not loaded");
  a_shift_in: assert property (@(posedge clk_in) disable iff (rst_in)
    sck_rise |=> shift_q[0] == $past(link_s2_q.serial_data)
      && shift_q[15:1] == $past(shift_q[14:0]))
    else $error("shift wrong");
  a_no_early: assert property (@(posedge clk_in) disable iff (rst_in)
    dac_load_out |-> $past(xfer_now))
    else $error("load without transfer");
  a_por_mid: assert property (@(posedge clk_in) disable iff (rst_in)
    !por_done_q |-> dac_latch_out == 16'h0000 && !dac_load_out)
    else $error("power-up not mid-scale");
  a_filt_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_s2_q.filter_clear_n |=> !filt_valid_out && !filt_run_out)
    else $error("filter active while cleared");
  a_filt_feed: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer_now && ctrl_s2_q.filter_clear_n
    |=> fvalid_q && fin_q == $past(hold_q))
    else $error("filter input not fed");
  a_filter_noload: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer_now && !bypass && ctrl_s2_q.output_clear_n |=> !dac_load_out)
    else $error("latch loaded while filter on");
  a_latch_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    por_done_q && !dac_load_out |-> $stable(dac_latch_out))
    else $error("latch changed without load");
  a_hold_only: assert property (@(posedge clk_in) disable iff (rst_in)
    por_done_q && !sync_fall |=> $stable(hold_q))
    else $error("holding register changed without word-sync fall");
  a_reset_mid: assert property (@(posedge clk_in)
    rst_in |=> dac_latch_out == 16'h0000 && !dac_load_out && !filt_valid_out)
    else $error("reset did not give mid-scale");
  a_run_level: assert property (@(posedge clk_in) disable iff (rst_in)
    por_done_q && ctrl_s2_q.filter_clear_n |=> filt_run_out)
    else $error("filter not running");
  a_no_push: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_s2_q.filter_clear_n |=> !fvalid_q)
    else $error("filter fed while cleared");
  a_filt_stand: assert property (@(posedge clk_in) disable iff (rst_in)
    filt_valid_out && !filt_ready_in && ctrl_s2_q.filter_clear_n
    |=> filt_valid_out && $stable(filt_data_out))
    else $error("filter word dropped before ready");
  a_overrun_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    fvalid_q && !frdy |=> overrun_out)
    else $error("lost filter word not flagged");
  c_bypass: cover property (@(posedge clk_in) dac_load_out && bypass);
  c_clear: cover property (@(posedge clk_in) dac_load_out && !ctrl_s2_q.output_clear_n);
  c_filter: cover property (@(posedge clk_in) filt_valid_out && filt_ready_in);
  c_full: cover property (@(posedge clk_in) !frdy);
  c_overrun: cover property (@(posedge clk_in) overrun_out);
endmodule

// Hand-off FIFO; depth must be a power of two so the pointers wrap cleanly
module mrjd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             push;
  logic             pop;
  assign wr_ready_out = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign rd_valid_out = wp_q != rp_q;
  assign rd_data_out  = mem_q[rp_q[AW-1:0]];
  assign push = wr_valid_in && wr_ready_out;
  assign pop  = rd_valid_out && rd_ready_in;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
    end else if (push) begin
      wp_q <= wp_q + 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rp_q <= '0;
    end else if (pop) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule

/* File: mrjd_pkg.sv */
/*
  Types of the serial input front end.
  Assumes mrjd_cfg.svh defines the word width.
*/
`include "mrjd_cfg.svh"
package mrjd_pkg;
  typedef logic [`MRJD_WORD_W-1:0] mrjd_word_t;
  typedef struct packed {
    logic serial_data;
    logic bit_clk;
    logic word_sync;
  } mrjd_link_s;
  typedef struct packed {
    logic filter_bypass_n;
    logic output_clear_n;
    logic filter_clear_n;
  } mrjd_ctrl_s;
  typedef enum logic [1:0] {MRJD_IDLE, MRJD_WAIT1, MRJD_WAIT2} mrjd_xfer_e;
endpackage

/* File: tb_top.sv */
/*
  Self-checking bench of the serial input front end.
  Assumes mrjd_host drives the link and a shortened power-up count.
*/
module tb_top
  import mrjd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in        = 1'b0;
  logic       rst_in        = 1'b1;
  logic       filt_ready_in = 1'b0;
  mrjd_ctrl_s ctrl          = 3'b111;
  mrjd_link_s link;
  mrjd_word_t dac_latch_out, filt_data_out;
  logic       dac_load_out, filt_valid_out, filt_run_out, overrun_out;
  int         n_errors = 0, total_checks = 0, n_load = 0, n_ovr = 0;
  realtime    t_load;
  always #2.5 clk_in = ~clk_in;
  mrjd_host host_u (.clk_in(clk_in), .link_out(link));
  mrjd_input #(.POR_CYCLES(20)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .link_in(link), .ctrl_in(ctrl), .dac_latch_out(dac_latch_out),
    .dac_load_out(dac_load_out), .filt_data_out(filt_data_out),
    .filt_valid_out(filt_valid_out), .filt_ready_in(filt_ready_in),
    .filt_run_out(filt_run_out), .overrun_out(overrun_out));
  always @(posedge clk_in) begin
    if (dac_load_out === 1'b1) begin
      n_load++;
      t_load = $realtime;
    end
    if (overrun_out === 1'b1)
      n_ovr++;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic frame(input mrjd_word_t w, input mrjd_word_t want, input int loads);
    int  n0;
    real d;
    n0 = n_load;
    host_u.send({~w[3:0], w});
    check("latch", dac_latch_out, want);
    check("loads", 16'(n_load - n0), 16'(loads));
    d = t_load - host_u.t_rise2;
    if (loads > 0)
      check("load_delay", 16'(d > 10.0 && d < 30.0), 16'h0001);
  endtask
  task automatic t_por();
    check("latch_por", dac_latch_out, 16'h0000);
    check("run_early", 16'(filt_run_out), 16'h0000);
    repeat (30) @(negedge clk_in);
    check("run_late", 16'(filt_run_out), 16'h0001);
    $display("test por done");
  endtask
  task automatic t_direct();
    mrjd_word_t codes [5] = '{16'h7FFF, 16'h8000, 16'h0000, 16'h4FFF, 16'hBFFF};
    ctrl = 3'b011;
    filt_ready_in = 1'b1;
    foreach (codes[i]) frame(codes[i], codes[i], 1);
    ctrl = 3'b001;
    frame(16'h5A5A, 16'h0000, 1);
    $display("test direct done");
  endtask
  task automatic t_filter();
    int k;
    ctrl = 3'b111;
    filt_ready_in = 1'b0;
    for (int i = 0; i < 11; i++) frame(16'h1000 + 16'(i), 16'h0000, 0);
    // Output slice plus eight FIFO words keep nine of the eleven
    check("overrun", 16'(n_ovr), 16'h0002);
    // Drain with a stall between words
    for (int i = 0; i < 8; i++) begin
      k = 0;
      while (filt_valid_out !== 1'b1 && k < 20) begin
        k++;
        @(negedge clk_in);
      end
      check("filt_word", filt_data_out, 16'h1000 + 16'(i));
      filt_ready_in = 1'b1;
      @(negedge clk_in);
      filt_ready_in = 1'b0;
      repeat (3) @(negedge clk_in);
    end
    $display("test filter done");
  endtask
  task automatic t_flush();
    ctrl = 3'b110;
    repeat (10) @(negedge clk_in);
    check("flushed", 16'(filt_valid_out), 16'h0000);
    check("run_off", 16'(filt_run_out), 16'h0000);
    frame(16'h2468, 16'h2468, 1);
    check("no_push", 16'(filt_valid_out), 16'h0000);
    $display("test flush done");
  endtask
  initial begin
    #100us;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    t_por();
    t_direct();
    t_filter();
    t_flush();
    report_and_stop();
  end
endmodule
